// file: rtl/drwg_params.svh
`ifndef DRWG_PARAMS_SVH
`define DRWG_PARAMS_SVH

// Register bus widths
`define DRWG_ADDR_W 4
`define DRWG_DATA_W 16

// Register word offsets
`define DRWG_OFS_CTRL 4'h0
`define DRWG_OFS_CMD 4'h1
`define DRWG_OFS_PERIOD 4'h2
`define DRWG_OFS_PERBUF 4'h3
`define DRWG_OFS_CC0 4'h4
`define DRWG_OFS_CC1 4'h5
`define DRWG_OFS_STATUS 4'h6
`define DRWG_OFS_COUNT 4'h7
`define DRWG_OFS_CAPT1 4'h8

// Control register field positions
`define DRWG_CTRL_ENABLE 0
`define DRWG_CTRL_ALT 1
`define DRWG_CTRL_CIRC 2
`define DRWG_CTRL_POL0 3
`define DRWG_CTRL_POL1 4
`define DRWG_CTRL_CAPT1 5

// Status register field positions
`define DRWG_STAT_RAMP_B 0
`define DRWG_STAT_HOLD 1
`define DRWG_STAT_CAPT 2
`define DRWG_STAT_PBUF 3

// Command field position and width
`define DRWG_CMD_LSB 0
`define DRWG_CMD_W 2

// Reset values
`define DRWG_RST_CTRL 6'h00
`define DRWG_RST_PERIOD 16'hffff
`define DRWG_RST_CC 16'h0000
`define DRWG_RST_DATA 16'h0000

// Counter step
`define DRWG_COUNT_STEP 16'h0001

`endif

// file: rtl/drwg_pin_sync.sv
`timescale 1ns/100ps
module drwg_pin_sync
   import drwg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Asynchronous pin
   input wire logic pin,
   // Synchronised level and its rising edge
   output logic level,
   output logic rise
);

   drwg_sync_t sync_reg;
   drwg_sync_t sync_next;

   // Edge detection compares the second stage with its delayed copy, never the first
   always_comb
   begin
      sync_next = sync_reg;
      sync_next.stage1 = pin;
      sync_next.stage2 = sync_reg.stage1;
      sync_next.prev = sync_reg.stage2;
      sync_next.rise = sync_reg.stage2 & ~sync_reg.prev;
   end

   // State register
   always_ff @(posedge mclk)
   begin
      if (reset)
         sync_reg <= '0;
      else
         sync_reg <= sync_next;
   end

   assign level = sync_reg.prev;
   assign rise = sync_reg.rise;

endmodule : drwg_pin_sync

// file: rtl/drwg_pkg.sv
package drwg_pkg;

   // Ramp index command values written through the command word
   typedef enum logic [1:0] {
      DRWG_CMD_NONE = 2'b00,
      DRWG_CMD_SET_A = 2'b01,
      DRWG_CMD_SET_B = 2'b10,
      DRWG_CMD_HOLD = 2'b11
   } drwg_ramp_index_command_t;

   // Software control bits
   typedef struct packed {
      logic capt1_en;
      logic pol1;
      logic pol0;
      logic circ;
      logic alt_mode;
      logic enable;
   } drwg_ctrl_t;

   // One register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } drwg_bus_req_t;

   // Whole state of the waveform generator
   typedef struct packed {
      drwg_ctrl_t ctrl;
      logic [15:0] count;
      logic [15:0] period;
      logic [15:0] perbuf;
      logic perbuf_valid;
      logic [15:0] cc0;
      logic [15:0] cc1;
      logic [15:0] capt1;
      logic capt_flag;
      logic ramp_b;
      logic hold;
      logic update;
      logic [1:0] wave;
      logic [15:0] rdata;
   } drwg_state_t;

   // State of the pin synchroniser
   typedef struct packed {
      logic stage1;
      logic stage2;
      logic prev;
      logic rise;
   } drwg_sync_t;

endpackage : drwg_pkg

// file: rtl/drwg_wavegen.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "drwg_params.svh"
module drwg_wavegen
   import drwg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire drwg_bus_req_t bus_req,
   output logic [15:0] rdata,
   // Capture pin for channel one
   input wire logic capture_pin,
   // Waveform outputs and ramp state
   output logic [1:0] waveform_output,
   output logic ramp_index,
   output logic update_pulse
);

   // Each ramp is one sweep of the counter from zero up to its top value.
   // Ramp A gates the odd output off and ramp B the even one. The ramp index
   // flips at every top unless software asked to hold it once, and a set-A or set-B
   // command written in the same cycle as the top wins over the flip.

   // Whole generator state and its next value; one register holds it all
   drwg_state_t q_reg;
   drwg_state_t q_next;
   // Synchronised capture edge and the update point
   logic capt_rise;
   logic at_top;
   // Write strobes, one per writable register offset
   logic wr_ctrl;
   logic wr_cmd;
   logic wr_period;
   logic wr_perbuf;
   logic wr_cc0;
   logic wr_cc1;
   logic wr_status;
   // Mode helpers for the odd output and channel one
   logic capture_active;
   logic src1;
   logic pol1_sel;
   logic gate_even;
   logic gate_odd;
   logic [15:0] cc_odd;
   // Decoded ramp index command from the write data
   drwg_ramp_index_command_t cmd;

   // Capture pin crosses into mclk before any logic reads it. Two stages
   // keep a metastable level away from the capture logic; the price is a
   // captured count that lags the pin edge by a few cycles.
   drwg_pin_sync u_capt_sync (
      .mclk(mclk),
      .reset(reset),
      .pin(capture_pin),
      .level(),
      .rise(capt_rise)
   );

   // Write decode for one register offset; the read strobe is ignored here
   // since the master never raises both strobes together
   function automatic logic wr_hit(input drwg_bus_req_t req, input logic [3:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction : wr_hit

   // Output level of one channel: active while count is below compare,
   // forced inactive when the ramp gates it off, then inverted by polarity.
   // Polarity is applied last, so a gated or disabled channel rests at its
   // polarity level rather than at a fixed low.
   function automatic logic wave_level(
      input logic enable,
      input logic [15:0] count,
      input logic [15:0] cc,
      input logic gate,
      input logic pol
   );
      wave_level = (enable && gate && (count < cc)) ^ pol;
   endfunction : wave_level

   // Read multiplexer. The command word is write only and, like every
   // unmapped offset, reads as zero.
   function automatic logic [15:0] read_word(input drwg_state_t s, input logic [3:0] ofs);
      read_word = `DRWG_RST_DATA;
      case (ofs)
         `DRWG_OFS_CTRL:
            read_word = {10'h000, s.ctrl};
         `DRWG_OFS_PERIOD:
            read_word = s.period;
         `DRWG_OFS_PERBUF:
            read_word = s.perbuf;
         `DRWG_OFS_CC0:
            read_word = s.cc0;
         `DRWG_OFS_CC1:
            read_word = s.cc1;
         `DRWG_OFS_STATUS:
         begin
            read_word[`DRWG_STAT_RAMP_B] = s.ramp_b;
            read_word[`DRWG_STAT_HOLD] = s.hold;
            read_word[`DRWG_STAT_CAPT] = s.capt_flag;
            read_word[`DRWG_STAT_PBUF] = s.perbuf_valid;
         end
         `DRWG_OFS_COUNT:
            read_word = s.count;
         `DRWG_OFS_CAPT1:
            read_word = s.capt1;
         default:
            read_word = `DRWG_RST_DATA;
      endcase
   endfunction : read_word

   // Bus decode and mode helpers. The update point only exists while the
   // counter runs, so a disabled generator only moves its ramp index on a command.
   always_comb
   begin
      // Count and capture words are read only and get no strobe
      wr_ctrl = wr_hit(bus_req, `DRWG_OFS_CTRL);
      wr_cmd = wr_hit(bus_req, `DRWG_OFS_CMD);
      wr_period = wr_hit(bus_req, `DRWG_OFS_PERIOD);
      wr_perbuf = wr_hit(bus_req, `DRWG_OFS_PERBUF);
      wr_cc0 = wr_hit(bus_req, `DRWG_OFS_CC0);
      wr_cc1 = wr_hit(bus_req, `DRWG_OFS_CC1);
      wr_status = wr_hit(bus_req, `DRWG_OFS_STATUS);
      // Command field decoded once for the override below
      cmd = drwg_ramp_index_command_t'(bus_req.wdata[`DRWG_CMD_LSB +: `DRWG_CMD_W]);
      // Top of the current ramp, only while the counter runs
      at_top = q_reg.ctrl.enable && (q_reg.count == q_reg.period);
      // Channel one is a capture channel in alternate mode or when asked to be
      capture_active = q_reg.ctrl.alt_mode || q_reg.ctrl.capt1_en;
   end

   // Source, gate and polarity of each output. The even output always
   // belongs to channel zero and is gated only by the ramp index.
   always_comb
   begin
      gate_even = ~q_reg.ramp_b;
      if (q_reg.ctrl.alt_mode)
      begin
         // Channel zero drives the odd output too, only with circular periods;
         // without them the odd output rests at its inactive level
         src1 = q_reg.ctrl.circ;
         pol1_sel = q_reg.ctrl.pol0;
         cc_odd = q_reg.cc0;
      end
      else
      begin
         // A capturing channel one produces no waveform
         src1 = ~q_reg.ctrl.capt1_en;
         pol1_sel = q_reg.ctrl.pol1;
         cc_odd = q_reg.cc1;
      end
      // The odd output only ever shows itself in ramp B
      gate_odd = q_reg.ramp_b && src1;
   end

   // Next state of the whole generator. Later assignments in this process
   // override earlier ones, which sets the priority of software over hardware except at the capture flag, where a new capture wins over a clear.
   always_comb
   begin
      q_next = q_reg;
      // Pulses and read data last one cycle unless set again below
      q_next.update = 1'b0;
      q_next.rdata = `DRWG_RST_DATA;

      // Counter runs 0 to period, then restarts. A disabled counter rests at
      // zero, so every enable starts a fresh ramp from its bottom.
      if (!q_reg.ctrl.enable)
         q_next.count = `DRWG_RST_DATA;
      else if (at_top)
         q_next.count = `DRWG_RST_DATA;
      else
         q_next.count = 16'(q_reg.count + `DRWG_COUNT_STEP);

      // Update point: ramp switches and period buffers load. A pending hold
      // skips one flip of the ramp index and is used up here, unless a no-op command written in the same cycle keeps it pending.
      if (at_top)
      begin
         q_next.update = 1'b1;
         if (q_reg.hold)
            q_next.hold = 1'b0;
         else
            q_next.ramp_b = ~q_reg.ramp_b;
         if (q_reg.ctrl.circ)
         begin
            // Swapping the pair lets ramps A and B each keep their own period;
            // software writes the buffer to change the period of the next ramp
            q_next.period = q_reg.perbuf;
            q_next.perbuf = q_reg.period;
         end
         else if (q_reg.perbuf_valid)
         begin
            // One period value serves both ramps
            q_next.period = q_reg.perbuf;
            q_next.perbuf_valid = 1'b0;
         end
      end

      // Register writes. They follow the update logic, so a direct period
      // write in the update cycle wins over the value loaded from the buffer.
      // Control bits act at once, so a mode change mid-ramp does not wait
      // for the next update.
      if (wr_ctrl)
         q_next.ctrl = drwg_ctrl_t'(bus_req.wdata[`DRWG_CTRL_CAPT1:`DRWG_CTRL_ENABLE]);
      if (wr_period)
         q_next.period = bus_req.wdata;
      if (wr_perbuf)
      begin
         // Written after the load so a write in the update cycle is kept
         q_next.perbuf = bus_req.wdata;
         q_next.perbuf_valid = 1'b1;
      end
      // Compare values also act at once; a write mid-ramp can shorten or
      // stretch the pulse already under way
      if (wr_cc0)
         q_next.cc0 = bus_req.wdata;
      if (wr_cc1)
         q_next.cc1 = bus_req.wdata;

      // Software index override comes after the update so it wins. Setting
      // the ramp outright also cancels a hold that has not been used yet.
      if (wr_cmd)
      begin
         case (cmd)
            DRWG_CMD_SET_A:
            begin
               q_next.ramp_b = 1'b0;
               q_next.hold = 1'b0;
            end
            DRWG_CMD_SET_B:
            begin
               q_next.ramp_b = 1'b1;
               q_next.hold = 1'b0;
            end
            DRWG_CMD_HOLD:
               q_next.hold = 1'b1;
            // A no-op command leaves a pending hold as it was
            default:
               q_next.hold = q_reg.hold;
         endcase
      end

      // Capture flag: write one clears, a new capture in the same cycle wins,
      // so an edge that arrives while software clears the flag is never lost
      if (wr_status && bus_req.wdata[`DRWG_STAT_CAPT])
         q_next.capt_flag = 1'b0;
      // Only a channel set up for capture records the count
      if (capt_rise && capture_active)
      begin
         q_next.capt1 = q_reg.count;
         q_next.capt_flag = 1'b1;
      end

      // Outputs registered from the current count, one cycle behind it;
      // the extra cycle is the cost of driving every pin from a flip-flop
      q_next.wave[0] = wave_level(q_reg.ctrl.enable, q_reg.count, q_reg.cc0,
                                  gate_even, q_reg.ctrl.pol0);
      q_next.wave[1] = wave_level(q_reg.ctrl.enable, q_reg.count, cc_odd,
                                  gate_odd, pol1_sel);

      // Read data appear in the cycle after the read strobe and fall back
      // to zero after it, since the default above clears them every cycle
      if (bus_req.rd)
         q_next.rdata = read_word(q_reg, bus_req.addr);
   end

   // State register; outputs idle at the inactive polarity of reset, low.
   // Reset loads only constants, so no field depends on another at reset.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         q_reg <= '0;
         q_reg.ctrl <= drwg_ctrl_t'(`DRWG_RST_CTRL);
         // Period registers reset to the full count range
         q_reg.period <= `DRWG_RST_PERIOD;
         q_reg.perbuf <= `DRWG_RST_PERIOD;
         q_reg.cc0 <= `DRWG_RST_CC;
         q_reg.cc1 <= `DRWG_RST_CC;
      end
      else
         q_reg <= q_next;
   end

   // Outputs straight from the state register; no logic sits between the
   // flip-flops and the pins, so downstream timing sees a clean launch
   assign rdata = q_reg.rdata;
   assign waveform_output = q_reg.wave;
   assign ramp_index = q_reg.ramp_b;
   assign update_pulse = q_reg.update;

endmodule : drwg_wavegen

// file: verif/drwg_wavegen_assertions.sv
`timescale 1ns/100ps
module drwg_wavegen_assertions
   import drwg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire drwg_bus_req_t bus_req,
   input wire logic [15:0] rdata,
   // Pins
   input wire logic capture_pin,
   input wire logic [1:0] waveform_output,
   input wire logic ramp_index,
   input wire logic update_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   drwg_ctrl_t ctrl_reg;
   logic hold_reg;
   logic cmd_wr;
   // Control and pending hold mirrored from bus writes
   assign cmd_wr = bus_req.wr && bus_req.addr == 4'h1;
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         ctrl_reg <= '0;
         hold_reg <= 1'b0;
      end
      else
      begin
         if (bus_req.wr && bus_req.addr == 4'h0)
            ctrl_reg <= drwg_ctrl_t'(bus_req.wdata[5:0]);
         if (cmd_wr && bus_req.wdata[1:0] == 2'b11)
            hold_reg <= 1'b1;
         else if (update_pulse || (cmd_wr && bus_req.wdata[1:0] != 2'b00))
            hold_reg <= 1'b0;
      end
   end
   a_rdata_idle: assert property (rdata != 16'h0000 |-> $past(bus_req.rd))
      else $error("read data outside read slot");
   a_cmd_reads_zero: assert property (bus_req.rd && bus_req.addr == 4'h1 |=> rdata == 16'h0000)
      else $error("command word read non zero");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > 4'h8 |=> rdata == 16'h0000)
      else $error("unmapped word read non zero");
   a_odd_off_a: assert property (!ramp_index && $past(!ramp_index) |-> waveform_output[1] ==
      ($past(ctrl_reg.alt_mode) ? $past(ctrl_reg.pol0) : $past(ctrl_reg.pol1)))
      else $error("odd output active in ramp A");
   a_even_off_b: assert property (ramp_index && $past(ramp_index) |->
      waveform_output[0] == $past(ctrl_reg.pol0))
      else $error("even output active in ramp B");
   a_idle_even_level: assert property (!$past(ctrl_reg.enable) |-> waveform_output[0] == $past(ctrl_reg.pol0))
      else $error("even output active while disabled");
   a_ramp_change_cause: assert property ($changed(ramp_index) |-> update_pulse || $past(cmd_wr))
      else $error("ramp index moved without update or command");
   a_toggle_on_update: assert property (update_pulse && !$past(hold_reg) && !$past(cmd_wr)
      |-> $changed(ramp_index))
      else $error("ramp index kept at update");
   // Main scenarios reached
   cover property (update_pulse);
   cover property ($rose(ramp_index));
   cover property (bus_req.rd ##1 rdata != 16'h0000);
endmodule : drwg_wavegen_assertions

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import drwg_pkg::*;
;
   logic mclk;
   logic reset;
   drwg_bus_req_t bus_req;
   logic [15:0] rdata;
   logic capture_pin;
   logic [1:0] waveform_output;
   logic ramp_index;
   logic update_pulse;
   int miscompares;
   int total_checks;
   int n0;
   int n1;
   logic [15:0] v;
   drwg_wavegen drwg_wavegen_i (.mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .capture_pin(capture_pin), .waveform_output(waveform_output), .ramp_index(ramp_index),
      .update_pulse(update_pulse));
   // 50 MHz clock
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // Bounded wait for the next update; n is the spacing in cycles
   task automatic wait_upd(output int n);
      n = 0;
      do
      begin
         @(posedge mclk);
         #1 n++;
      end while (update_pulse !== 1'b1 && n < 200);
      if (n >= 200)
      begin
         miscompares++;
         $display("mismatch at %0t: no update", $time);
         stop_test();
      end
   endtask : wait_upd
   // High cycles of each output over a window; any full window gives the same sum
   task automatic win(int len, output int h0, output int h1);
      h0 = 0;
      h1 = 0;
      repeat (len)
      begin
         @(posedge mclk);
         #1 h0 += int'(waveform_output[0]);
         h1 += int'(waveform_output[1]);
      end
   endtask : win
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   initial
   begin
      reset = 1'b1;
      bus_req = '0;
      capture_pin = 1'b0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      rd(4'h0, v);
      chk(v, 16'h0000);
      rd(4'h2, v);
      chk(v, 16'hffff);
      rd(4'hf, v);
      chk(v, 16'h0000);
      $display("reset test done");
      // Standard mode: period 3, compare 2 and 1
      wr(4'h2, 16'h0003);
      wr(4'h4, 16'h0002);
      wr(4'h5, 16'h0001);
      wr(4'h0, 16'h0001);
      wait_upd(n0);
      v[0] = ramp_index;
      wait_upd(n0);
      chk(16'(n0), 16'h0004);
      chk(16'(ramp_index), {15'h0000, ~v[0]});
      win(8, n0, n1);
      chk(16'(n0), 16'h0002);
      chk(16'(n1), 16'h0001);
      // Channel one capturing with pol1 set: odd output rests high
      wr(4'h0, 16'h0031);
      wait_upd(n0);
      win(8, n0, n1);
      chk(16'(n0), 16'h0002);
      chk(16'(n1), 16'h0008);
      rd(4'h4, v);
      chk(v, 16'h0002);
      $display("standard test done");
      // Hold skips exactly one toggle
      wait_upd(n0);
      v[0] = ramp_index;
      wr(4'h1, 16'h0003);
      wait_upd(n0);
      chk(16'(ramp_index), 16'(v[0]));
      wait_upd(n0);
      chk(16'(ramp_index), {15'h0000, ~v[0]});
      $display("hold test done");
      // Index override while stopped, then circular periods 3 and 1
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0002);
      #1 chk(16'(ramp_index), 16'h0001);
      wr(4'h1, 16'h0001);
      #1 chk(16'(ramp_index), 16'h0000);
      rd(4'h1, v);
      chk(v, 16'h0000);
      wr(4'h3, 16'h0001);
      wr(4'h0, 16'h0005);
      wait_upd(n0);
      wait_upd(n0);
      wait_upd(n1);
      chk(16'(n0 + n1), 16'h0006);
      chk(16'(n0 * n1), 16'h0008);
      $display("circular test done");
      // Alternate mode, pol0 set: compare 2 drives both outputs active low
      wr(4'h0, 16'h000f);
      wait_upd(n0);
      wait_upd(n0);
      win(6, n0, n1);
      chk(16'(12 - n0 - n1), 16'h0004);
      @(posedge mclk);
      capture_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(4'h6, v);
      chk(v & 16'h0004, 16'h0004);
      wr(4'h6, 16'h0004);
      rd(4'h6, v);
      chk(v & 16'h0004, 16'h0000);
      $display("alternate test done");
      stop_test();
   end
endmodule : tb_top
bind drwg_wavegen drwg_wavegen_assertions drwg_wavegen_assertions_i (.mclk(mclk), .reset(reset),
   .bus_req(bus_req), .rdata(rdata), .capture_pin(capture_pin), .waveform_output(waveform_output),
   .ramp_index(ramp_index), .update_pulse(update_pulse));
